// ===== logic/mrx_sys_rx.sv
`timescale 1ns/1ps
`default_nettype none
module mrx_sys_rx #(
    parameter int DW = 64,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Configuration
    input wire logic i_long_length_check_enable,
    input wire logic i_short_length_check_enable,
    input wire logic i_length_type_check_enable,
    input wire logic i_pause_rx_enable,
    input wire logic i_crc_check_enable,
    input wire logic [15:0] i_max_packet_length_cfg,
    input wire logic i_rx_local_loopback_enable,
    input wire logic i_tx_local_loopback_enable,
    input wire logic i_rx_hold,
    // Line-side receive beats
    input wire logic i_line_valid,
    input wire logic i_line_sop,
    input wire logic i_line_eop,
    input wire logic [7:0] i_line_bc,
    input wire logic [DW-1:0] i_line_data,
    input wire logic [DW-1:0] i_line_preamble,
    input wire logic i_line_frame_err,
    input wire logic i_line_crc_err,
    input wire logic i_line_stomp_err,
    // Receive loopback inputs
    input wire logic i_rx_loopback_clock_in,
    input wire logic [31:0] i_rx_loopback_call_in,
    input wire logic [DW-1:0] i_rx_loopback_control_in,
    input wire logic [DW-1:0] i_rx_loopback_data_in,
    // Transmit words for loopback
    input wire logic [31:0] i_tx_call,
    input wire logic [DW-1:0] i_tx_control,
    input wire logic [DW-1:0] i_tx_data,
    // System-side receive packet interface
    output logic o_rx_valid,
    output logic o_rx_start_of_packet,
    output logic o_rx_end_of_packet,
    output logic o_rx_error,
    output logic [7:0] o_rx_error_flags,
    output logic [7:0] o_rx_byte_count,
    output logic [DW-1:0] o_rx_preamble,
    output logic [DW-1:0] o_rx_data,
    output logic o_rx_fifo_overflow,
    output logic [39:0] o_rx_statistics_vector,
    // Transmit loopback outputs
    output logic o_tx_loopback_clock_out,
    output logic [31:0] o_tx_loopback_call_out,
    output logic [DW-1:0] o_tx_loopback_control_out,
    output logic [DW-1:0] o_tx_loopback_data_out
);
    import mrx_pkg::*;

    localparam int LANES = DW / 8;
    localparam int MW = $bits(mrx_meta_s);
    localparam int FW = 2 * DW + MW;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // Loopback clock synchroniser and selected source
    logic lb_s1, lb_s2, lb_s3, lb_level, lb_rise, next_lb_level;
    logic src_valid, src_sop, src_eop, src_frame, src_crc, src_stomp;
    logic [7:0] src_bc;
    logic [DW-1:0] src_data, src_pre;

    // Write side
    mrx_wr_state_e state, next_state;
    logic [15:0] len, next_len, len_base, len_new, lt_val, next_lt, lt_cur, lt_exp;
    logic long_s, next_long, frame_s, next_frame, long_c, frame_c;
    logic [7:0] errw_c;
    logic [LANES-1:0] hit_hi, hit_lo;
    logic [7:0] lane_hi [LANES];
    logic [7:0] lane_lo [LANES];
    logic [7:0] byte_hi, byte_lo;
    logic room, full, wr_valid, wr_ready, ovf_pulse;
    logic [CW-1:0] count;
    mrx_meta_s wr_meta, rd_meta;
    logic [FW-1:0] rd_word;
    logic rd_valid, rd_ready;

    // Read side and loopback transmit
    logic next_valid, next_sop, next_eop, next_err;
    logic [7:0] next_flags, next_bc;
    logic [DW-1:0] next_pre, next_data;
    logic [15:0] rlen, next_rlen, rbeats, next_rbeats;
    logic [39:0] next_stats;
    logic next_tclk;
    logic [31:0] next_tcall;
    logic [DW-1:0] next_tctrl, next_tdata;

    always_comb
    begin
        lb_rise = lb_s2 && lb_s3 && !lb_level;
        next_lb_level = (lb_s2 == lb_s3) ? lb_s3 : lb_level;
        if (i_rx_local_loopback_enable)
        begin
            src_valid = lb_rise && i_rx_loopback_call_in[MRX_CALL_VALID];
            src_sop = i_rx_loopback_call_in[MRX_CALL_SOP];
            src_eop = i_rx_loopback_call_in[MRX_CALL_EOP];
            src_bc = i_rx_loopback_call_in[MRX_CALL_BC_LSB +: 8];
            src_data = i_rx_loopback_data_in;
            src_pre = '0;
            src_frame = |i_rx_loopback_control_in;
            src_crc = 1'b0;
            src_stomp = 1'b0;
        end
        else
        begin
            src_valid = i_line_valid;
            src_sop = i_line_sop;
            src_eop = i_line_eop;
            src_bc = i_line_bc;
            src_data = i_line_data;
            src_pre = i_line_preamble;
            src_frame = i_line_frame_err;
            src_crc = i_line_crc_err;
            src_stomp = i_line_stomp_err;
        end
    end

    assign len_base = src_sop ? MRX_LEN_RESET : len;

    // Per-lane capture of the length/type bytes
    for (genvar j = 0; j < LANES; j++)
    begin : g_lane
        logic [15:0] pos;
        assign pos = len_base + 16'(j);
        assign hit_hi[j] = (8'(j) < src_bc) && (pos == MRX_LT_HI_POS);
        assign hit_lo[j] = (8'(j) < src_bc) && (pos == MRX_LT_LO_POS);
        assign lane_hi[j] = hit_hi[j] ? src_data[8*j +: 8] : 8'h00;
        assign lane_lo[j] = hit_lo[j] ? src_data[8*j +: 8] : 8'h00;
    end

    always_comb
    begin
        byte_hi = 8'h00;
        byte_lo = 8'h00;
        for (int k = 0; k < LANES; k++)
        begin
            byte_hi = byte_hi | lane_hi[k];
            byte_lo = byte_lo | lane_lo[k];
        end
    end

    // Error vector of the beat on the source
    always_comb
    begin
        len_new = len_base + {8'h00, src_bc};
        lt_cur[15:8] = (|hit_hi) ? byte_hi : lt_val[15:8];
        lt_cur[7:0] = (|hit_lo) ? byte_lo : lt_val[7:0];
        // Short payloads are padded, so compare against the padded size
        lt_exp = ((lt_cur < MRX_MIN_PAYLOAD) ? MRX_MIN_PAYLOAD : lt_cur) + MRX_HDR_FCS_BYTES;
        long_c = i_long_length_check_enable && ((long_s && !src_sop) || (len_new > i_max_packet_length_cfg));
        frame_c = (frame_s && !src_sop) || src_frame;
        errw_c = 8'h00;
        errw_c[MRX_ERR_PAUSE] = src_eop && i_pause_rx_enable && (lt_cur == MRX_PAUSE_TYPE);
        errw_c[MRX_ERR_LT] = src_eop && i_length_type_check_enable && (lt_cur < MRX_LT_TYPE_LIMIT)
            && (len_new != lt_exp);
        errw_c[MRX_ERR_LONG] = long_c;
        errw_c[MRX_ERR_SHORT] = src_eop && i_short_length_check_enable && (len_new < MRX_MIN_FRAME_BYTES);
        errw_c[MRX_ERR_STOMP] = src_eop && i_crc_check_enable && src_stomp;
        errw_c[MRX_ERR_CRC] = src_eop && i_crc_check_enable && src_crc;
        errw_c[MRX_ERR_FRAME] = frame_c;
    end

    // Write state machine; one slot stays free for a closing beat
    always_comb
    begin
        room = count < CW'(FIFO_DEPTH - 1);
        full = !wr_ready;
        next_state = state;
        next_len = len;
        next_long = long_s;
        next_frame = frame_s;
        next_lt = lt_val;
        wr_valid = 1'b0;
        wr_meta = '{sop: src_sop, eop: src_eop, bc: src_bc, errw: errw_c};
        ovf_pulse = 1'b0;
        if (src_valid)
        begin
            next_len = len_new;
            next_long = long_c;
            next_frame = frame_c;
            next_lt = lt_cur;
            case (state)
                MRX_ST_IDLE:
                begin
                    if (src_sop && !room)
                    begin
                        ovf_pulse = 1'b1;
                        next_state = src_eop ? MRX_ST_IDLE : MRX_ST_DROP;
                    end
                    else if (src_sop)
                    begin
                        wr_valid = 1'b1;
                        next_state = src_eop ? MRX_ST_IDLE : MRX_ST_PASS;
                    end
                end
                MRX_ST_PASS:
                begin
                    if (room || (src_eop && !full))
                    begin
                        wr_valid = 1'b1;
                        next_state = src_eop ? MRX_ST_IDLE : MRX_ST_PASS;
                    end
                    else
                    begin
                        ovf_pulse = 1'b1;
                        wr_valid = !full;
                        wr_meta.eop = 1'b1;
                        wr_meta.errw[MRX_ERR_FRAME] = 1'b1;
                        next_state = src_eop ? MRX_ST_IDLE : MRX_ST_DROP;
                    end
                end
                MRX_ST_DROP:
                begin
                    next_state = src_eop ? MRX_ST_IDLE : MRX_ST_DROP;
                end
                default:
                begin
                    next_state = MRX_ST_IDLE;
                end
            endcase
        end
    end

    mrx_rx_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_wr_valid(wr_valid),
        .i_wr_data({src_pre, src_data, wr_meta}),
        .o_wr_ready(wr_ready),
        .o_count(count),
        .i_rd_ready(rd_ready),
        .o_rd_valid(rd_valid),
        .o_rd_data(rd_word)
    );

    // Read side: stall under hold lets the FIFO really fill
    always_comb
    begin
        rd_ready = !i_rx_hold;
        rd_meta = rd_word[MW-1:0];
        next_valid = rd_valid && rd_ready;
        next_sop = next_valid && rd_meta.sop;
        next_eop = next_valid && rd_meta.eop;
        next_flags = next_valid ? rd_meta.errw : 8'h00;
        next_flags[MRX_ERR_UNUSED] = 1'b0;
        next_err = |next_flags;
        next_bc = next_valid ? rd_meta.bc : o_rx_byte_count;
        next_data = next_valid ? rd_word[MW +: DW] : o_rx_data;
        next_pre = next_valid ? rd_word[MW + DW +: DW] : o_rx_preamble;
        next_rlen = rlen;
        next_rbeats = rbeats;
        next_stats = o_rx_statistics_vector;
        if (next_valid)
        begin
            next_rlen = (rd_meta.sop ? MRX_LEN_RESET : rlen) + {8'h00, rd_meta.bc};
            next_rbeats = (rd_meta.sop ? MRX_LEN_RESET : rbeats) + 16'h0001;
            if (rd_meta.eop)
            begin
                next_stats = {next_rbeats, next_flags, next_rlen};
            end
        end
    end

    // Transmit loopback, clock is i_clk halved
    always_comb
    begin
        next_tclk = i_tx_local_loopback_enable && !o_tx_loopback_clock_out;
        next_tcall = o_tx_loopback_call_out;
        next_tctrl = o_tx_loopback_control_out;
        next_tdata = o_tx_loopback_data_out;
        if (!i_tx_local_loopback_enable)
        begin
            next_tcall = '0;
            next_tctrl = '0;
            next_tdata = '0;
        end
        else if (next_tclk)
        begin
            next_tcall = i_tx_call;
            next_tctrl = i_tx_control;
            next_tdata = i_tx_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            {lb_s1, lb_s2, lb_s3, lb_level} <= 4'h0;
            state <= MRX_ST_IDLE;
            len <= MRX_LEN_RESET;
            lt_val <= MRX_LEN_RESET;
            long_s <= 1'b0;
            frame_s <= 1'b0;
            rlen <= MRX_LEN_RESET;
            rbeats <= MRX_LEN_RESET;
            o_rx_valid <= 1'b0;
            o_rx_start_of_packet <= 1'b0;
            o_rx_end_of_packet <= 1'b0;
            o_rx_error <= 1'b0;
            o_rx_error_flags <= 8'h00;
            o_rx_byte_count <= 8'h00;
            o_rx_preamble <= '0;
            o_rx_data <= '0;
            o_rx_fifo_overflow <= 1'b0;
            o_rx_statistics_vector <= MRX_STATS_RESET;
            o_tx_loopback_clock_out <= 1'b0;
            o_tx_loopback_call_out <= '0;
            o_tx_loopback_control_out <= '0;
            o_tx_loopback_data_out <= '0;
        end
        else
        begin
            lb_s1 <= i_rx_loopback_clock_in;
            lb_s2 <= lb_s1;
            lb_s3 <= lb_s2;
            lb_level <= next_lb_level;
            state <= next_state;
            len <= next_len;
            lt_val <= next_lt;
            long_s <= next_long;
            frame_s <= next_frame;
            rlen <= next_rlen;
            rbeats <= next_rbeats;
            o_rx_valid <= next_valid;
            o_rx_start_of_packet <= next_sop;
            o_rx_end_of_packet <= next_eop;
            o_rx_error <= next_err;
            o_rx_error_flags <= next_flags;
            o_rx_byte_count <= next_bc;
            o_rx_preamble <= next_pre;
            o_rx_data <= next_data;
            o_rx_fifo_overflow <= ovf_pulse;
            o_rx_statistics_vector <= next_stats;
            o_tx_loopback_clock_out <= next_tclk;
            o_tx_loopback_call_out <= next_tcall;
            o_tx_loopback_control_out <= next_tctrl;
            o_tx_loopback_data_out <= next_tdata;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    logic long_seen;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            long_seen <= 1'b0;
        else if (o_rx_valid)
            long_seen <= o_rx_error_flags[MRX_ERR_LONG] && !o_rx_end_of_packet;
    end

    a_err_aggregate: assert property (o_rx_valid && (|o_rx_error_flags) |-> o_rx_error)
        else $error("aggregate error missing");
    a_long_hold: assert property (o_rx_valid && long_seen && !o_rx_start_of_packet
        && $stable(i_long_length_check_enable) && i_long_length_check_enable |-> o_rx_error_flags[MRX_ERR_LONG])
        else $error("long flag dropped before end");
    a_pause_on_eop: assert property (o_rx_error_flags[MRX_ERR_PAUSE] |-> o_rx_end_of_packet && o_rx_error)
        else $error("pause flag off end beat");
    a_short_on_eop: assert property (o_rx_error_flags[MRX_ERR_SHORT] |-> o_rx_end_of_packet && o_rx_error)
        else $error("short flag off end beat");
    a_short_length: assert property (wr_valid && wr_meta.errw[MRX_ERR_SHORT] |-> len_new < 16'h0040)
        else $error("short flag on long packet");
    a_gated_checks: assert property (wr_valid |-> (!wr_meta.errw[MRX_ERR_LT] || i_length_type_check_enable)
        && (!wr_meta.errw[MRX_ERR_LONG] || i_long_length_check_enable)
        && (!wr_meta.errw[MRX_ERR_SHORT] || i_short_length_check_enable)
        && (!wr_meta.errw[MRX_ERR_PAUSE] || i_pause_rx_enable))
        else $error("disabled check raised a flag");
    a_trunc_marked: assert property (ovf_pulse && state == MRX_ST_PASS && !full
        |-> wr_valid && wr_meta.eop && wr_meta.errw[MRX_ERR_FRAME] ##1 o_rx_fifo_overflow)
        else $error("overflowed packet not closed");
    a_drop_whole: assert property (state == MRX_ST_DROP |-> !wr_valid)
        else $error("dropped packet written");
    a_ovf_cause: assert property (o_rx_fifo_overflow |-> $past(src_valid) && !$past(room))
        else $error("overflow without cause");
    a_ctrl_low: assert property (!o_rx_valid |-> !o_rx_start_of_packet && !o_rx_end_of_packet && !o_rx_error)
        else $error("qualifier high without valid");
    a_lpbk_ignored: assert property (!i_rx_local_loopback_enable && !i_line_valid |-> !src_valid)
        else $error("loopback used while disabled");
    a_msb_low: assert property (!o_rx_error_flags[MRX_ERR_UNUSED])
        else $error("unused flag bit high");
    a_tx_lpbk_idle: assert property (!i_tx_local_loopback_enable |=> !o_tx_loopback_clock_out
        && o_tx_loopback_call_out == 32'h00000000)
        else $error("loopback driven while disabled");

    c_overflow: cover property (ovf_pulse && state == MRX_ST_PASS);
    c_drop_new: cover property (ovf_pulse && state == MRX_ST_IDLE);
    c_pause: cover property (o_rx_error_flags[MRX_ERR_PAUSE]);
    c_loopback_pkt: cover property (i_rx_local_loopback_enable && o_rx_end_of_packet);
endmodule
`default_nettype wire

// ===== pkg/mrx_pkg.sv
package mrx_pkg;

    // Frame geometry in bytes, then length/type field values
    localparam logic [15:0] MRX_MIN_FRAME_BYTES = 16'h0040;
    localparam logic [15:0] MRX_LT_HI_POS = 16'h000C;
    localparam logic [15:0] MRX_LT_LO_POS = 16'h000D;
    localparam logic [15:0] MRX_HDR_FCS_BYTES = 16'h0012;
    localparam logic [15:0] MRX_MIN_PAYLOAD = 16'h002E;
    localparam logic [15:0] MRX_LT_TYPE_LIMIT = 16'h0600;
    localparam logic [15:0] MRX_PAUSE_TYPE = 16'h8808;

    // Error-flag vector bit positions
    localparam int MRX_ERR_PAUSE = 0;
    localparam int MRX_ERR_LT = 1;
    localparam int MRX_ERR_LONG = 2;
    localparam int MRX_ERR_SHORT = 3;
    localparam int MRX_ERR_STOMP = 4;
    localparam int MRX_ERR_CRC = 5;
    localparam int MRX_ERR_FRAME = 6;
    localparam int MRX_ERR_UNUSED = 7;

    // Loopback call word layout
    localparam int MRX_CALL_VALID = 0;
    localparam int MRX_CALL_SOP = 1;
    localparam int MRX_CALL_EOP = 2;
    localparam int MRX_CALL_BC_LSB = 3;

    // Values after reset
    localparam logic [15:0] MRX_LEN_RESET = 16'h0000;
    localparam logic [39:0] MRX_STATS_RESET = 40'h0000000000;

    typedef struct packed {
        logic sop;
        logic eop;
        logic [7:0] bc;
        logic [7:0] errw;
    } mrx_meta_s;

    typedef enum logic [2:0] {
        MRX_ST_IDLE = 3'b001,
        MRX_ST_PASS = 3'b010,
        MRX_ST_DROP = 3'b100
    } mrx_wr_state_e;

endpackage

// ===== logic/mrx_rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module mrx_rx_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Fill side
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    output logic [CW-1:0] o_count,
    // Drain side
    input wire logic i_rd_ready,
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic [AW-1:0] next_wptr;
    logic [AW-1:0] next_rptr;
    logic [CW-1:0] next_count;
    logic wr_fire;
    logic rd_fire;

    always_comb
    begin
        wr_fire = i_wr_valid && (count != CW'(DEPTH));
        rd_fire = i_rd_ready && (count != '0);
        next_wptr = wptr;
        next_rptr = rptr;
        if (wr_fire)
        begin
            next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
        end
        if (rd_fire)
        begin
            next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
        end
        next_count = count + CW'(wr_fire) - CW'(rd_fire);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    // Storage has no reset; contents are qualified by the count
    always_ff @(posedge i_clk)
    begin
        if (wr_fire)
        begin
            mem[wptr] <= i_wr_data;
        end
    end

    assign o_wr_ready = (count != CW'(DEPTH));
    assign o_count = count;
    assign o_rd_valid = (count != '0);
    assign o_rd_data = mem[rptr];
endmodule
`default_nettype wire

// ===== testbench/mrx_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module mrx_sink_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Received beats and stall mode
    input wire logic i_valid,
    input wire logic i_sop,
    input wire logic i_eop,
    input wire logic [63:0] i_data,
    input wire logic [1:0] i_mode,
    // Stall and boundary faults
    output logic o_hold,
    output int o_bad
);
    int seed = 32'hE7308976;
    logic in_pkt = 1'b0;
    initial o_hold = 1'b0;
    initial o_bad = 0;
    // In mode 2 no two stalls in a row, so the FIFO drains at least every other cycle; mode 1 stalls every cycle
    always @(posedge i_clk)
        o_hold <= i_rstn && (i_mode == 2'h1 || (i_mode == 2'h2 && !o_hold && $random(seed) % 4 == 0));
    always @(negedge i_clk)
    begin
        if (i_valid === 1'b1)
        begin
            if (i_sop !== !in_pkt || ^i_data === 1'bx)
                o_bad <= o_bad + 1;
            in_pkt = !i_eop;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/mrx_sys_rx_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t %0h %0h", $time, a, b); end end
module mrx_sys_rx_tb_top;
    import mrx_pkg::*;
    typedef struct packed {logic sop; logic eop; logic [7:0] bc; logic [7:0] fl; logic [63:0] d; logic [63:0] pre;} mrx_tb_beat_s;
    logic i_clk = '0, i_rstn = '0, i_long_length_check_enable = '0, i_short_length_check_enable = '0;
    logic i_length_type_check_enable = '0, i_pause_rx_enable = '0, i_crc_check_enable = '0, i_rx_hold;
    logic i_rx_local_loopback_enable = '0, i_tx_local_loopback_enable = '0, i_line_valid = '0, i_line_sop = '0;
    logic i_line_eop = '0, i_line_frame_err = '0, i_line_crc_err = '0, i_line_stomp_err = '0;
    logic i_rx_loopback_clock_in = '0, v, st_chk = '0, lb_clk = '0;
    logic [1:0] mode = 2'h2;
    logic [7:0] i_line_bc = '0, o_rx_error_flags, o_rx_byte_count;
    logic [15:0] i_max_packet_length_cfg = 16'h0040, st_b, st_n;
    logic [31:0] i_rx_loopback_call_in = 32'h00000000, i_tx_call = '0, o_tx_loopback_call_out;
    logic [63:0] i_line_data = '0, i_line_preamble = '0, i_rx_loopback_control_in = '0, i_rx_loopback_data_in = '0;
    logic [63:0] i_tx_control = '0, i_tx_data = '0, o_rx_preamble, o_rx_data, o_tx_loopback_control_out;
    logic [63:0] o_tx_loopback_data_out;
    logic o_rx_valid, o_rx_start_of_packet, o_rx_end_of_packet, o_rx_error, o_rx_fifo_overflow, o_tx_loopback_clock_out;
    logic [39:0] o_rx_statistics_vector;
    int failures = 0, checks_done = 0, cyc = 0, ovf = 0, ov0, bad, seed = 32'hE7308976;
    int lens[5] = '{60, 64, 80, 64, 72};
    logic [15:0] lts[5] = '{16'h0010, 16'h8808, 16'h0800, 16'h002E, 16'h0020};
    mrx_tb_beat_s exp_q[$];
    mrx_tb_beat_s e;

    mrx_sys_rx #(.DW(64), .FIFO_DEPTH(16)) i_dut (.*);
    mrx_sink_model i_sink (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(o_rx_valid), .i_sop(o_rx_start_of_packet),
        .i_eop(o_rx_end_of_packet), .i_data(o_rx_data), .i_mode(mode), .o_hold(i_rx_hold), .o_bad(bad));

    always #12.5 i_clk = ~i_clk;
    // Loopback clock jitters while unused; any beat taken then is unexpected
    always @(posedge i_clk)
        i_rx_loopback_clock_in <= i_rx_local_loopback_enable ? lb_clk : 1'($random(seed));
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [7:0] eop_fl(int len, logic [15:0] lt, logic ce);
        eop_fl = 8'h00;
        eop_fl[0] = i_pause_rx_enable && lt == MRX_PAUSE_TYPE;
        eop_fl[1] = i_length_type_check_enable && lt < 16'h0600 && len != ((lt < 16'h002E) ? 46 : int'(lt)) + 18;
        eop_fl[3] = i_short_length_check_enable && len < 64;
        eop_fl[4] = i_crc_check_enable && ce;
        eop_fl[5] = i_crc_check_enable && ce;
    endfunction

    // Cut: beat index truncated by overflow, -1 drops the packet whole
    task automatic send_pkt(input int len, input logic [15:0] lt, input int cut);
        int nb;
        logic ce;
        mrx_tb_beat_s b;
        nb = (len + 7) / 8;
        for (int k = 0; k < nb; k++)
        begin
            @(posedge i_clk);
            b.sop = (k == 0);
            b.eop = (k == nb - 1) || (k == cut);
            b.bc = (k == nb - 1) ? 8'(len - 8 * k) : 8'h08;
            b.d = {$random(seed), $random(seed)};
            b.pre = {$random(seed), $random(seed)};
            if (k == 1)
                b.d[47:32] = {lt[7:0], lt[15:8]};
            ce = (k == nb - 1) && $random(seed) % 2 == 0;
            b.fl = {5'h00, i_long_length_check_enable && 8 * k + int'(b.bc) > int'(i_max_packet_length_cfg), 2'h0};
            if (k == nb - 1)
                b.fl |= eop_fl(len, lt, ce);
            if (k == cut)
                b.fl = 8'h40;
            if (k <= cut)
                exp_q.push_back(b);
            {i_line_valid, i_line_sop, i_line_eop, i_line_bc} <= {1'b1, b.sop, 1'(k == nb - 1), b.bc};
            {i_line_data, i_line_preamble, i_line_crc_err, i_line_stomp_err} <= {b.d, b.pre, ce, ce};
        end
        @(posedge i_clk);
        i_line_valid <= 1'b0;
    endtask

    task automatic drain();
        for (int w = 0; w < 400 && exp_q.size() != 0; w++)
            @(posedge i_clk);
        `CHK(exp_q.size(), 0)
    endtask

    always @(negedge i_clk)
    begin
        if (st_chk)
            `CHK({o_rx_statistics_vector[39:24], o_rx_statistics_vector[15:0]}, {st_b, st_n})
        st_chk = 1'b0;
        if (o_rx_fifo_overflow === 1'b1)
            ovf++;
        if (o_rx_valid === 1'b1)
        begin
            `CHK(exp_q.size() != 0, 1'b1)
            e = exp_q.pop_front();
            `CHK({o_rx_start_of_packet, o_rx_end_of_packet, o_rx_byte_count, o_rx_data}, {e.sop, e.eop, e.bc, e.d})
            `CHK({o_rx_error_flags, o_rx_error}, {e.fl, |e.fl})
            if (e.sop)
                `CHK(o_rx_preamble, e.pre)
            st_b = e.sop ? 16'h0001 : st_b + 16'h0001;
            st_n = (e.sop ? 16'h0000 : st_n) + 16'(e.bc);
            st_chk = e.eop && !e.fl[6];
        end
        else
            `CHK({o_rx_valid, o_rx_start_of_packet, o_rx_end_of_packet, o_rx_error, o_rx_error_flags}, 12'h000)
    end

    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        // Descending so the overflow run sees every check off
        for (int m = 31; m >= 0; m--)
        begin
            @(posedge i_clk);
            {i_crc_check_enable, i_pause_rx_enable, i_length_type_check_enable} <= 3'(m >> 2);
            {i_short_length_check_enable, i_long_length_check_enable} <= 2'(m);
            foreach (lens[j])
                send_pkt(lens[j], lts[j], 99);
            drain();
        end
        mode <= 2'h1;
        repeat (3) @(posedge i_clk);
        ov0 = ovf;
        send_pkt(160, 16'h0800, 15);
        send_pkt(16, 16'h0800, -1);
        repeat (4) @(posedge i_clk);
        `CHK(ovf - ov0, 2)
        mode <= 2'h2;
        drain();
        // Call valid stays clear until the synchroniser has settled low
        i_rx_local_loopback_enable <= 1'b1;
        i_rx_loopback_data_in <= 64'h0123456789ABCDEF;
        repeat (6) @(posedge i_clk);
        exp_q.push_back('{1'b1, 1'b1, 8'h08, 8'h00, 64'h0123456789ABCDEF, 64'h0000000000000000});
        {i_rx_loopback_call_in, lb_clk} <= {32'h00000047, 1'b1};
        drain();
        @(negedge i_clk);
        `CHK({bad, o_tx_loopback_clock_out, o_tx_loopback_call_out}, 65'h0)
        @(posedge i_clk);
        {i_tx_call, i_tx_control, i_tx_data} <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
        i_tx_local_loopback_enable <= 1'b1;
        repeat (6) @(negedge i_clk);
        v = o_tx_loopback_clock_out;
        `CHK({o_tx_loopback_call_out, o_tx_loopback_control_out, o_tx_loopback_data_out}, {i_tx_call, i_tx_control, i_tx_data})
        @(negedge i_clk);
        `CHK(o_tx_loopback_clock_out, ~v)
        report_and_stop();
    end
endmodule
`default_nettype wire
